/* tb/pdac_dev_model.sv */
// behavioural model of the parallel dac write port, octal variant
// assumes pins driven by pdac_host; the bench reads its state hierarchically
`timescale 1ns/1ps
`default_nettype none
module pdac_dev_model (
  input wire logic       chip_select_n,
  input wire logic       write_strobe_n,
  input wire logic       mode_pin,
  input wire logic [2:0] chan,
  input wire logic [9:0] data_lines,
  input wire logic       output_update_strobe_n,
  input wire logic       hardware_clear_n
);
  logic [9:0] gctl_r;
  logic [9:0] cctl_r     [8];
  logic [9:0] main_r     [8];
  logic [7:0] trim_r     [8];
  logic [9:0] main_dac_r [8];
  logic [7:0] trim_dac_r [8];
  initial
  begin
    gctl_r = 10'h030;
    for (int i = 0; i < 8; i++)
    begin
      cctl_r[i] = 10'h018;
      main_r[i] = 10'h000;
      trim_r[i] = 8'h00;
      main_dac_r[i] = 10'h000;
      trim_dac_r[i] = 8'h00;
    end
  end
  // latch on the trailing strobe edge
  always @(posedge write_strobe_n)
    if (!chip_select_n)
    begin
      if (!mode_pin && data_lines[0]) cctl_r[chan] <= data_lines;
      else if (!mode_pin) gctl_r <= data_lines;
      else if (gctl_r[7] && data_lines[0]) trim_r[chan] <= data_lines[9:2];
      else if (gctl_r[7] && data_lines[1]) main_r[chan][1:0] <= data_lines[3:2];
      else if (gctl_r[7]) main_r[chan][9:2] <= data_lines[9:2];
      else if (cctl_r[chan][7]) trim_r[chan] <= data_lines[9:2];
      else main_r[chan] <= data_lines;
    end
  always @(negedge output_update_strobe_n or negedge hardware_clear_n)
    for (int i = 0; i < 8; i++)
    begin
      if (!hardware_clear_n)
      begin
        main_dac_r[i] <= 10'h000;
        trim_dac_r[i] <= gctl_r[6] ? 8'h80 : 8'h00;
      end
      else
      begin
        main_dac_r[i] <= (cctl_r[i][3] || gctl_r[3]) ? 10'h000 : main_r[i];
        trim_dac_r[i] <= trim_r[i];
      end
    end
endmodule : pdac_dev_model
`default_nettype wire

/* tb/pdac_host_tb_top.sv */
// self-checking bench for pdac_host against the device model
// assumes 250 MHz clk and the designer's command word layout
`timescale 1ns/1ps
`default_nettype none
module pdac_host_tb_top;
  typedef struct {logic [2:0] op; logic [2:0] ch; logic [1:0] sub; logic [9:0] wd; int kind; logic [9:0] exp;} pdac_row_t;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic        cs_n, wr_n, mode, a2, a1, a0, upd_n, clr_n;
  logic [9:0]  lines;
  int          n_fail = 0;
  int          tests_run = 0;
  int          ncmd = 0;
  logic [15:0] rd;
  pdac_row_t   rows [21] = '{
    '{3'h0, 3'h0, 2'h0, 10'h060, 0, 10'h060}, '{3'h1, 3'h3, 2'h0, 10'h110, 1, 10'h111},
    '{3'h1, 3'h7, 2'h0, 10'h090, 1, 10'h091}, '{3'h1, 3'h5, 2'h0, 10'h010, 1, 10'h011},
    '{3'h2, 3'h3, 2'h0, 10'h2A5, 2, 10'h2A5}, '{3'h2, 3'h7, 2'h0, 10'h0C3, 3, 10'h0C3},
    '{3'h2, 3'h0, 2'h0, 10'h3FF, 2, 10'h3FF}, '{3'h3, 3'h3, 2'h0, 10'h000, 4, 10'h2A5},
    '{3'h3, 3'h7, 2'h0, 10'h000, 5, 10'h0C3}, '{3'h1, 3'h3, 2'h0, 10'h018, 1, 10'h019},
    '{3'h3, 3'h3, 2'h0, 10'h000, 4, 10'h000}, '{3'h0, 3'h0, 2'h0, 10'h0E0, 0, 10'h0E0},
    '{3'h2, 3'h5, 2'h0, 10'h2D4, 2, 10'h2D4}, '{3'h2, 3'h5, 2'h1, 10'h003, 2, 10'h2D7},
    '{3'h2, 3'h5, 2'h2, 10'h05A, 3, 10'h05A}, '{3'h2, 3'h7, 2'h0, 10'h100, 2, 10'h100},
    '{3'h3, 3'h5, 2'h0, 10'h000, 4, 10'h2D7}, '{3'h4, 3'h5, 2'h0, 10'h000, 5, 10'h080},
    '{3'h4, 3'h5, 2'h0, 10'h000, 4, 10'h000}, '{3'h0, 3'h0, 2'h0, 10'h020, 0, 10'h020},
    '{3'h4, 3'h7, 2'h0, 10'h000, 5, 10'h000}};

  pdac_host dut_u (.clk(clk), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .chip_select_n(cs_n), .write_strobe_n(wr_n), .mode_pin(mode),
    .channel_addr_2(a2), .channel_addr_1(a1), .channel_addr_0(a0), .data_lines(lines),
    .output_update_strobe_n(upd_n), .hardware_clear_n(clr_n));
  pdac_dev_model dev_u (.chip_select_n(cs_n), .write_strobe_n(wr_n), .mode_pin(mode), .chan({a2, a1, a0}),
    .data_lines(lines), .output_update_strobe_n(upd_n), .hardware_clear_n(clr_n));

  initial forever #2 clk = ~clk;

  task automatic final_report;
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write

  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read

  // poll busy with a bounded count
  task automatic wait_idle;
    logic [15:0] s;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 100; i++)
    begin
      sw_read(4'h2, s);
      if (s[0] === 1'b0) return;
    end
    $display("MISMATCH %0t controller stuck busy", $time);
    n_fail++;
  endtask : wait_idle

  task automatic cmd(input logic [2:0] op, input logic [2:0] ch, input logic [1:0] sub, input logic [9:0] wd);
    sw_write(4'h1, {6'h00, wd});
    sw_write(4'h0, {sub, 1'b0, ch, 7'h00, op});
    ncmd++;
    wait_idle();
  endtask : cmd

  function automatic logic [9:0] model_val(input int kind, input logic [2:0] ch);
    case (kind)
      0: return dev_u.gctl_r;
      1: return dev_u.cctl_r[ch];
      2: return dev_u.main_r[ch];
      3: return {2'b00, dev_u.trim_r[ch]};
      4: return dev_u.main_dac_r[ch];
      default: return {2'b00, dev_u.trim_dac_r[ch]};
    endcase
  endfunction : model_val

  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1 chk({12'h000, cs_n, wr_n, upd_n, clr_n}, 16'h000F);
    sw_read(4'h3, rd);
    chk(rd, 16'h0030);
    sw_read(4'hF, rd);
    chk(rd, 16'h0000);
    foreach (rows[i])
    begin
      cmd(rows[i].op, rows[i].ch, rows[i].sub, rows[i].wd);
      chk({6'h00, model_val(rows[i].kind, rows[i].ch)}, {6'h00, rows[i].exp});
    end
    // commands while busy must be dropped
    sw_write(4'h1, 16'h0111);
    sw_write(4'h0, 16'h0402);
    ncmd++;
    sw_write(4'h1, 16'h0222);
    sw_write(4'h0, 16'h0402);
    wait_idle();
    chk({6'h00, dev_u.main_r[1]}, 16'h0111);
    sw_read(4'h1, rd);
    chk(rd, 16'h0111);
    sw_read(4'h2, rd);
    chk({8'h00, rd[15:8]}, {8'h00, 8'(ncmd)});
    // reset in mid-transfer, before the strobe
    sw_write(4'h1, 16'h03FF);
    sw_write(4'h0, 16'h0802);
    repeat (3) @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    #1 chk({12'h000, cs_n, wr_n, upd_n, clr_n}, 16'h000F);
    sw_read(4'h2, rd);
    chk(rd, 16'h0000);
    // wait past where the cut strobe would have ended
    repeat (20) @(posedge clk);
    chk({6'h00, dev_u.main_r[2]}, 16'h0000);
    final_report();
  end
endmodule : pdac_host_tb_top
`default_nettype wire

/* verilog/pdac_consts.svh */
// constants for the parallel dac host controller
// assumes a 250 MHz clk; included by pdac_host
// Notes on behaviour
// - mode pin high writes data registers, low writes control registers
// - in 10-bit loading, stored channel target bit routes data to main or sub
// - host asserts chip select and write strobe with address to load a register
// - byte mode: line 1 low loads high eight bits, high loads two low bits
// - byte mode: line 0 picks main when low, trim when high
// - channel soft clear needs an update strobe after the clear bit write
`ifndef PDAC_CONSTS_SVH
`define PDAC_CONSTS_SVH
`define PDAC_ADDR_CMD     4'h0
`define PDAC_ADDR_WDATA   4'h1
`define PDAC_ADDR_STATUS  4'h2
`define PDAC_ADDR_PINS    4'h3
`define PDAC_CMD_GCTL     3'h0
`define PDAC_CMD_CCTL     3'h1
`define PDAC_CMD_DATA     3'h2
`define PDAC_CMD_UPDATE   3'h3
`define PDAC_CMD_CLEAR    3'h4
`define PDAC_CMD_RAW      3'h5
`define PDAC_BIT_BYTE     7
`define PDAC_BIT_CODING   6
`define PDAC_BIT_PWR      5
`define PDAC_BIT_CHANNEL_SLEEP_N     4
`define PDAC_BIT_GLOBAL_SOFT_CLEAR     3
`define PDAC_BIT_BIAS_HI  9
`define PDAC_BIT_BIAS_LO  8
`define PDAC_BIT_TARGET   7
`define PDAC_BIT_SLEEP_N  4
`define PDAC_BIT_CCLR     3
`define PDAC_GCTL_RESET   10'h030
`define PDAC_CCTL_RESET   10'h018
`define PDAC_T_SETUP_NS   20
`define PDAC_T_STROBE_NS  40
`define PDAC_T_HOLD_NS    20
`define PDAC_CLK_NS       4
`define PDAC_CYC(ns)      (((ns) + `PDAC_CLK_NS - 1) / `PDAC_CLK_NS)
`endif

/* verilog/pdac_host.sv */
// host controller driving the parallel write port of a 10-bit multi-channel dac
// assumes software on a simple strobe port; device pins are plain outputs
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pdac_consts.svh"
module pdac_host
  import pdac_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [3:0] sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic [15:0]     sw_rdata,
  output logic            chip_select_n,
  output logic            write_strobe_n,
  output logic            mode_pin,
  output logic            channel_addr_2,
  output logic            channel_addr_1,
  output logic            channel_addr_0,
  output logic [9:0]      data_lines,
  output logic            output_update_strobe_n,
  output logic            hardware_clear_n
);
  localparam logic [7:0] SETUP_CYC = 8'(`PDAC_CYC(`PDAC_T_SETUP_NS));
  localparam logic [7:0] STRB_CYC  = 8'(`PDAC_CYC(`PDAC_T_STROBE_NS));
  localparam logic [7:0] HOLD_CYC  = 8'(`PDAC_CYC(`PDAC_T_HOLD_NS));

  pdac_seq_if seq ();
  pdac_timer u_timer (.clk(clk), .rstn(rstn), .seq(seq));

  pdac_state_t st_r, st_nxt;
  pdac_line_t  line_r, line_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        cs_n_r, cs_n_nxt, wr_n_r, wr_n_nxt, mode_r, mode_nxt;
  logic [2:0]  addr_r, addr_nxt;
  logic [9:0]  dl_r, dl_nxt;
  logic        upd_n_r, upd_n_nxt, clr_n_r, clr_n_nxt;
  logic [9:0]  gctl_r, gctl_nxt;
  logic [7:0]  tgt_r, tgt_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        start_nxt;
  logic [7:0]  count_nxt;
  logic [2:0]  ch;
  logic [1:0]  sub;
  logic        busy;

  assign busy = (st_r != PD_IDLE);
  assign ch   = sw_wdata[12:10];
  assign sub  = sw_wdata[15:14];
  assign seq.start = start_nxt;
  assign seq.count = count_nxt;

  always_comb
  begin
    st_nxt = st_r;
    line_nxt = line_r;
    wdata_nxt = wdata_r;
    cs_n_nxt = cs_n_r;
    wr_n_nxt = wr_n_r;
    mode_nxt = mode_r;
    addr_nxt = addr_r;
    dl_nxt = dl_r;
    upd_n_nxt = upd_n_r;
    clr_n_nxt = clr_n_r;
    gctl_nxt = gctl_r;
    tgt_nxt = tgt_r;
    cnt_nxt = cnt_r;
    start_nxt = 1'b0;
    count_nxt = 8'h00;
    rdata_nxt = 16'h0000;
    if (sw_rd)
    begin
      unique case (sw_addr)
        `PDAC_ADDR_STATUS: rdata_nxt = {cnt_r, 7'h00, busy};
        `PDAC_ADDR_WDATA:  rdata_nxt = wdata_r;
        `PDAC_ADDR_PINS:   rdata_nxt = {6'h00, gctl_r};
        default:           rdata_nxt = 16'h0000;
      endcase
    end
    if (sw_wr && sw_addr == `PDAC_ADDR_WDATA && !busy)
    begin
      wdata_nxt = sw_wdata;
    end
    unique case (st_r)
      PD_IDLE:
      begin
        if (sw_wr && sw_addr == `PDAC_ADDR_CMD)
        begin
          addr_nxt = ch;
          line_nxt = PD_LINE_WR;
          start_nxt = 1'b1;
          count_nxt = SETUP_CYC;
          st_nxt = PD_SETUP;
          cnt_nxt = cnt_r + 8'h01;
          unique case (sw_wdata[2:0])
            `PDAC_CMD_GCTL:
            begin
              mode_nxt = 1'b0;
              dl_nxt = {wdata_r[9:3], 1'b0, 1'b0, 1'b0};
              gctl_nxt = {wdata_r[9:3], 3'b000};
            end
            `PDAC_CMD_CCTL:
            begin
              mode_nxt = 1'b0;
              dl_nxt = {wdata_r[9:3], 1'b0, 1'b0, 1'b1};
              tgt_nxt[ch] = wdata_r[`PDAC_BIT_TARGET];
            end
            `PDAC_CMD_DATA:
            begin
              mode_nxt = 1'b1;
              if (!gctl_r[`PDAC_BIT_BYTE])
              begin
                dl_nxt = wdata_r[9:0];
                if (tgt_r[ch])
                begin
                  dl_nxt = {wdata_r[7:0], 2'b00};
                end
              end
              else if (sub[1])
              begin
                dl_nxt = {wdata_r[7:0], 1'b0, 1'b1};
              end
              else if (sub[0])
              begin
                dl_nxt = {6'h00, wdata_r[1:0], 1'b1, 1'b0};
              end
              else
              begin
                dl_nxt = {wdata_r[9:2], 1'b0, 1'b0};
              end
            end
            `PDAC_CMD_UPDATE:
            begin
              line_nxt = PD_LINE_UPD;
              upd_n_nxt = 1'b0;
              count_nxt = STRB_CYC;
              st_nxt = PD_PULSE;
            end
            `PDAC_CMD_CLEAR:
            begin
              line_nxt = PD_LINE_CLR;
              clr_n_nxt = 1'b0;
              count_nxt = STRB_CYC;
              st_nxt = PD_PULSE;
            end
            default:
            begin
              mode_nxt = sw_wdata[3];
              dl_nxt = wdata_r[9:0];
            end
          endcase
        end
      end
      PD_SETUP:
      begin
        cs_n_nxt = 1'b0;
        if (seq.done)
        begin
          wr_n_nxt = 1'b0;
          start_nxt = 1'b1;
          count_nxt = STRB_CYC;
          st_nxt = PD_STRB;
        end
      end
      PD_STRB:
      begin
        if (seq.done)
        begin
          wr_n_nxt = 1'b1;
          start_nxt = 1'b1;
          count_nxt = HOLD_CYC;
          st_nxt = PD_HOLD;
        end
      end
      PD_HOLD:
      begin
        if (seq.done)
        begin
          cs_n_nxt = 1'b1;
          st_nxt = PD_IDLE;
        end
      end
      PD_PULSE:
      begin
        if (seq.done)
        begin
          // release only the line that this pulse drove
          if (line_r == PD_LINE_UPD)
          begin
            upd_n_nxt = 1'b1;
          end
          else
          begin
            clr_n_nxt = 1'b1;
          end
          st_nxt = PD_IDLE;
        end
      end
      default:
      begin
        st_nxt = PD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= PD_IDLE;
      line_r <= PD_LINE_WR;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      mode_r <= 1'b0;
      addr_r <= 3'h0;
      dl_r <= 10'h000;
      upd_n_r <= 1'b1;
      clr_n_r <= 1'b1;
      gctl_r <= `PDAC_GCTL_RESET;
      tgt_r <= 8'h00;
      cnt_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      line_r <= line_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      cs_n_r <= cs_n_nxt;
      wr_n_r <= wr_n_nxt;
      mode_r <= mode_nxt;
      addr_r <= addr_nxt;
      dl_r <= dl_nxt;
      upd_n_r <= upd_n_nxt;
      clr_n_r <= clr_n_nxt;
      gctl_r <= gctl_nxt;
      tgt_r <= tgt_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign sw_rdata = rdata_r;
  assign chip_select_n = cs_n_r;
  assign write_strobe_n = wr_n_r;
  assign mode_pin = mode_r;
  assign channel_addr_2 = addr_r[2];
  assign channel_addr_1 = addr_r[1];
  assign channel_addr_0 = addr_r[0];
  assign data_lines = dl_r;
  assign output_update_strobe_n = upd_n_r;
  assign hardware_clear_n = clr_n_r;

  sequence s_strobe_low;
    !write_strobe_n [*1];
  endsequence
  a_strobe_inside_cs: assert property (@(posedge clk) disable iff (!rstn)
    !write_strobe_n |-> !chip_select_n) else $error("strobe outside select");
  a_data_stable_wr: assert property (@(posedge clk) disable iff (!rstn)
    s_strobe_low ##1 !write_strobe_n |-> $stable(data_lines) && $stable(mode_pin)) else $error("data moved");
  a_ctl_bit_two: assert property (@(posedge clk) disable iff (!rstn)
    (!write_strobe_n && !mode_pin) |-> data_lines[2:1] == 2'b00) else $error("bit two set");
  a_strobe_ends: assert property (@(posedge clk) disable iff (!rstn)
    $fell(write_strobe_n) |-> ##[1:20] write_strobe_n) else $error("strobe stuck");
  a_upd_ends: assert property (@(posedge clk) disable iff (!rstn)
    $fell(output_update_strobe_n) |-> ##[1:20] output_update_strobe_n) else $error("update stuck");
  a_clr_ends: assert property (@(posedge clk) disable iff (!rstn)
    $fell(hardware_clear_n) |-> ##[1:20] hardware_clear_n) else $error("clear stuck");
  a_upd_no_cs: assert property (@(posedge clk) disable iff (!rstn)
    !output_update_strobe_n |-> chip_select_n) else $error("update during write");
  a_byte_sub: assert property (@(posedge clk) disable iff (!rstn)
    (!write_strobe_n && mode_pin && gctl_r[`PDAC_BIT_BYTE] && data_lines[0]) |-> !data_lines[1])
    else $error("trim with low-half flag");
endmodule : pdac_host
`default_nettype wire

/* verilog/pdac_pkg.sv */
// types for the parallel dac host controller
// assumes pdac_consts.svh alongside
package pdac_pkg;
  typedef enum logic [2:0] {
    PD_IDLE  = 3'b000,
    PD_SETUP = 3'b001,
    PD_STRB  = 3'b010,
    PD_HOLD  = 3'b011,
    PD_PULSE = 3'b100
  } pdac_state_t;
  typedef enum logic [1:0] {
    PD_LINE_WR  = 2'b00,
    PD_LINE_UPD = 2'b01,
    PD_LINE_CLR = 2'b10
  } pdac_line_t;
endpackage : pdac_pkg

/* verilog/pdac_seq_if.sv */
// pulse request/done carrier between the controller and its timer
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface pdac_seq_if;
  logic       start;
  logic [7:0] count;
  logic       done;
  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface : pdac_seq_if
`default_nettype wire

/* verilog/pdac_timer.sv */
// cycle timer: counts a phase length and pulses done at its end
// assumes start is one cycle and count is at least one
`timescale 1ns/1ps
`default_nettype none
module pdac_timer
  import pdac_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  pdac_seq_if.tmr  seq
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       done_r;
  logic       done_nxt;
  assign seq.done = done_r;
  always_comb
  begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (seq.start)
    begin
      cnt_nxt = seq.count;
    end
    else if (cnt_r != 8'h00)
    begin
      cnt_nxt  = cnt_r - 8'h01;
      done_nxt = (cnt_r == 8'h01);
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r  <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end
endmodule : pdac_timer
`default_nettype wire
